// >>> design/astm_pkg.sv
// Constants, carrier types and states shared by the transport mapper.
package astm_pkg;

    // ==========================================================
    // Sizes
    localparam int CH_MAX        = 4;   // Converter channels A..D
    localparam int SMP_PER_FRAME = 10;  // Most samples of one channel per frame
    localparam int SMP_W         = 9;   // Converter resolution
    localparam int OCTET_W       = 8;
    localparam int FRAME_W       = 64;  // Eight octets, the longest lane frame
    localparam int LANE_MAX      = 8;
    localparam int LANE_ID_W     = 3;
    localparam int DEV_ID_W      = 8;
    localparam int K_W           = 9;

    // ==========================================================
    // Link mode codes that carry a mapping here
    localparam logic [3:0] MODE_0 = 4'h0;
    localparam logic [3:0] MODE_1 = 4'h1;
    localparam logic [3:0] MODE_2 = 4'h2;
    localparam logic [3:0] MODE_3 = 4'h3;
    localparam logic [3:0] MODE_5 = 4'h5;

    // ==========================================================
    // Field layout inside a lane frame
    localparam int PAD12_W   = 3;   // 9-bit sample padded to 12 bits
    localparam int PAD10_W   = 1;   // 9-bit sample padded to 10 bits
    localparam int SLOT12_W  = 12;
    localparam int SLOT10_W  = 10;
    localparam int M0_SLOTS  = 5;   // Samples per lane frame, mode 0
    localparam int M3_SLOTS  = 4;   // Samples per lane frame, mode 3
    localparam int M0_LANES_PER_CH = 2;
    localparam int M1_LANES_PER_GRP = 3;

    // ==========================================================
    // Frames-per-multiframe limits
    localparam logic [K_W-1:0] K_MAX      = 9'h100;
    localparam logic [K_W-1:0] K_STEP_M0  = 9'h004;
    localparam logic [K_W-1:0] K_STEP_M1  = 9'h010;
    localparam logic [K_W-1:0] K_STEP_M23 = 9'h020;
    localparam int K64_OCTETS = 8;  // K = octets x blocks x E / F
    localparam int K64_BLOCKS = 32;

    // ==========================================================
    // Carriers
    typedef logic [SMP_W-1:0] astm_sample_t;

    typedef struct packed {
        astm_sample_t [CH_MAX-1:0][SMP_PER_FRAME-1:0] smp;
    } astm_frame_in_t;

    typedef struct packed {
        logic           enc_64b;    // 1: 64B/66B, 0: 8B/10B
        logic [3:0]     lanes;      // L
        logic [3:0]     conv_m;     // M
        logic [3:0]     octets_f;   // F
        logic [2:0]     samples_s;  // S
        logic [3:0]     res_n;      // N
        logic [3:0]     width_np;   // N'
        logic [1:0]     ext_e;      // E
        logic [K_W-1:0] frames_k;   // K
    } astm_link_params_t;

    typedef enum logic [0:0] {
        LINK_IDLE = 1'b0,
        LINK_RUN  = 1'b1
    } astm_link_state_t;

endpackage : astm_pkg

// >>> design/astm_mapper.sv
// Transport-layer mapper placing converter samples into lane frames.
`timescale 1ns/100ps

// Summary of operation
// - Eight lanes, or four on single-channel variant
// - Lowest lanes carry data, higher lanes powered down
// - Lane id is lane index; device id configured
// - Frame layout follows selected link mode
// - Tail bits always zero
// - Samples placed most significant bit first
// - Extra low-order positions padded with zeros
// - 64B/66B K derived as 8*32*E/F
// - K input ignored in 64B/66B modes
// - Mode 0: M equals L, time-ordered, no extra buffering
// - Mode 3: one lane per channel, N'=10, F=5, S=4
// - Mode 5: 64B/66B, F=2, S=1, K=128
// - Channel A..D sample n, T is zero tail
// - Mode 0: five 12-bit slots, tail nibble
// - Mode 1 lane 0: A0 padded, A1 top
// - Mode 3: four 10-bit samples over five octets
module astm_mapper #(
    parameter  int NUM_CH = 4,  // 4 quad, 2 dual, 1 single
    localparam int NL     = (NUM_CH == 1) ? 4 : 8
) (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    // Link configuration
    input  wire logic                          link_enable,
    input  wire logic [3:0]                    link_mode_select,
    input  wire logic [astm_pkg::K_W-1:0]      k_setting,
    input  wire logic [astm_pkg::DEV_ID_W-1:0] device_identifier_setting,
    // Converter samples, one frame's worth per valid
    input  wire astm_pkg::astm_frame_in_t      sample_in,
    input  wire logic                          sample_valid,
    // Lane frames
    output logic [NL-1:0][astm_pkg::FRAME_W-1:0]   lane_frame,
    output logic [NL-1:0]                          lane_active,
    output logic                                   frame_valid,
    output logic [NL-1:0][astm_pkg::LANE_ID_W-1:0] lane_identifier,
    output logic [astm_pkg::DEV_ID_W-1:0]          device_identifier,
    // Link status
    output astm_pkg::astm_link_params_t            link_params,
    output logic                                   link_running,
    output logic                                   config_error
);
    // ==========================================================
    // Elaboration check: only the three variants have a lane map
    if (NUM_CH != 1 && NUM_CH != 2 && NUM_CH != 4) begin : g_bad_ch
        $error("NUM_CH must be 1, 2 or 4");
    end

    // ==========================================================
    // Helpers

    // Channels absent in this variant read as zero samples
    function automatic astm_pkg::astm_sample_t smp(
        input astm_pkg::astm_frame_in_t fi, input int ch, input int idx);
        smp = '0;
        if (ch < NUM_CH && idx < astm_pkg::SMP_PER_FRAME)
            smp = fi.smp[ch][idx];
    endfunction : smp

    // Derived link parameters; error on unmapped mode or bad K
    function automatic logic derive(
        input  logic [3:0]                  mode,
        input  logic [astm_pkg::K_W-1:0]    k_in,
        output astm_pkg::astm_link_params_t p);
        logic [astm_pkg::K_W-1:0] step;
        logic                     err;
        p    = '0;
        step = astm_pkg::K_STEP_M23;
        err  = 1'b0;
        case (mode)
            astm_pkg::MODE_0: begin
                p.lanes = 4'(2 * NUM_CH);
                p.conv_m = p.lanes;
                p.octets_f = 4'h8;
                p.samples_s = 3'h5;
                p.res_n = 4'h9;
                p.width_np = 4'hc;
                step = astm_pkg::K_STEP_M0;
            end
            astm_pkg::MODE_1: begin
                p.lanes = (NUM_CH == 1) ? 4'h2 : 4'(3 * NUM_CH / 2);
                p.conv_m = 4'(NUM_CH);
                p.octets_f = 4'h2;
                p.samples_s = 3'h2;
                p.res_n = 4'h9;
                p.width_np = 4'hc;
                step = astm_pkg::K_STEP_M1;
            end
            astm_pkg::MODE_2: begin
                p.lanes = 4'(NUM_CH);
                p.conv_m = (NUM_CH == 1) ? 4'h4 : 4'(NUM_CH);
                p.octets_f = 4'h1;
                p.samples_s = 3'h1;
                p.res_n = 4'h8;
                p.width_np = 4'h8;
            end
            astm_pkg::MODE_3: begin
                p.lanes = 4'(NUM_CH);
                p.conv_m = (NUM_CH == 1) ? 4'h4 : 4'(NUM_CH);
                p.octets_f = 4'h5;
                p.samples_s = 3'h4;
                p.res_n = 4'h9;
                p.width_np = 4'ha;
            end
            astm_pkg::MODE_5: begin
                p.enc_64b = 1'b1;
                p.lanes = (NUM_CH == 4) ? 4'h2 : 4'h1;
                p.conv_m = (NUM_CH == 2) ? 4'h2 : 4'h4;
                p.octets_f = 4'h2;
                p.samples_s = 3'h1;
                p.res_n = 4'h8;
                p.width_np = 4'h8;
                p.ext_e = 2'h1;
            end
            default: err = 1'b1;  // No mapping: every lane stays down
        endcase
        if (!err && p.enc_64b) begin
            // K follows E and F; the K input is not consulted
            p.frames_k = astm_pkg::K_W'(astm_pkg::K64_OCTETS
                         * astm_pkg::K64_BLOCKS * int'(p.ext_e)
                         / int'(p.octets_f));
        end else if (!err) begin
            // Out-of-range or off-step K falls back to the least value
            if (k_in < step || k_in > astm_pkg::K_MAX
                || (k_in % step) != '0) begin
                err        = 1'b1;
                p.frames_k = step;
            end else begin
                p.frames_k = k_in;
            end
        end
        derive = err;
    endfunction : derive

    // One lane's frame, left-justified: octet 0 in the top bits
    function automatic logic [astm_pkg::FRAME_W-1:0] build(
        input logic [3:0] mode, input int lane,
        input astm_pkg::astm_frame_in_t fi);
        logic [astm_pkg::FRAME_W-1:0] f;
        astm_pkg::astm_sample_t       a0;
        astm_pkg::astm_sample_t       a1;
        astm_pkg::astm_sample_t       b0;
        astm_pkg::astm_sample_t       b1;
        int                           ch;
        int                           pos;
        f   = '0;  // Tail and unused positions stay zero
        ch  = 0;
        pos = 0;
        a0  = '0;
        a1  = '0;
        b0  = '0;
        b1  = '0;
        case (mode)
            astm_pkg::MODE_0: begin
                // Lane pair per channel: even indices, then odd
                ch  = lane / astm_pkg::M0_LANES_PER_CH;
                pos = lane % astm_pkg::M0_LANES_PER_CH;
                for (int i = 0; i < astm_pkg::M0_SLOTS; i++) begin
                    f[astm_pkg::FRAME_W-1-i*astm_pkg::SLOT12_W
                      -: astm_pkg::SLOT12_W] =
                        {smp(fi, ch, pos + 2 * i),
                         astm_pkg::PAD12_W'(0)};
                end
            end
            astm_pkg::MODE_1: begin
                ch  = 2 * (lane / astm_pkg::M1_LANES_PER_GRP);
                pos = lane % astm_pkg::M1_LANES_PER_GRP;
                a0  = smp(fi, ch, 0);
                a1  = smp(fi, ch, 1);
                b0  = smp(fi, ch + 1, 0);
                b1  = smp(fi, ch + 1, 1);
                if (pos == 0)
                    f[63 -: 16] = {a0, 3'h0, a1[8:5]};
                else if (pos == 1)
                    f[63 -: 16] = {a1[4:0], 3'h0, b0[8:1]};
                else
                    f[63 -: 16] = {b0[0], 3'h0, b1, 3'h0};
            end
            astm_pkg::MODE_2: begin
                a0 = smp(fi, lane, 0);
                f[63 -: astm_pkg::OCTET_W] = a0[8:1];  // Top eight bits
            end
            astm_pkg::MODE_3: begin
                for (int i = 0; i < astm_pkg::M3_SLOTS; i++) begin
                    f[astm_pkg::FRAME_W-1-i*astm_pkg::SLOT10_W
                      -: astm_pkg::SLOT10_W] =
                        {smp(fi, lane, i),
                         astm_pkg::PAD10_W'(0)};
                end
            end
            astm_pkg::MODE_5: begin
                a0 = smp(fi, 2 * lane, 0);
                b0 = smp(fi, 2 * lane + 1, 0);
                f[63 -: 16] = {a0[8:1], b0[8:1]};
            end
            default: f = '0;
        endcase
        build = f;
    endfunction : build

    // ==========================================================
    // Link control state
    astm_pkg::astm_link_state_t  state;
    astm_pkg::astm_link_state_t  next_state;
    astm_pkg::astm_link_params_t params;
    astm_pkg::astm_link_params_t next_params;
    astm_pkg::astm_link_params_t cand_params;
    logic [3:0]                  mode;
    logic [3:0]                  next_mode;
    logic [astm_pkg::DEV_ID_W-1:0] dev_id;
    logic [astm_pkg::DEV_ID_W-1:0] next_dev_id;
    logic                        cfg_err;
    logic                        next_cfg_err;
    logic                        cand_err;

    // Settings are sampled only when enable is high in idle, and frozen while running,
    // so the lanes never see a half-changed configuration
    always_comb begin
        cand_err     = derive(link_mode_select, k_setting, cand_params);
        next_state   = state;
        next_params  = params;
        next_mode    = mode;
        next_dev_id  = dev_id;
        next_cfg_err = cfg_err;
        case (state)
            astm_pkg::LINK_IDLE: begin
                if (link_enable) begin
                    next_state   = astm_pkg::LINK_RUN;
                    next_params  = cand_params;
                    next_mode    = link_mode_select;
                    next_dev_id  = device_identifier_setting;
                    next_cfg_err = cand_err;
                end
            end
            astm_pkg::LINK_RUN: begin
                if (!link_enable)
                    next_state = astm_pkg::LINK_IDLE;
            end
            default: next_state = astm_pkg::LINK_IDLE;
        endcase
    end

    // Control registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state   <= astm_pkg::LINK_IDLE;
            params  <= '0;
            mode    <= astm_pkg::MODE_0;
            dev_id  <= '0;
            cfg_err <= 1'b0;
        end else begin
            state   <= next_state;
            params  <= next_params;
            mode    <= next_mode;
            dev_id  <= next_dev_id;
            cfg_err <= next_cfg_err;
        end
    end

    // ==========================================================
    // Per-lane framing
    logic                                 running;
    logic [NL-1:0][astm_pkg::FRAME_W-1:0] next_frame;
    logic                                 next_fvalid;

    assign running = (state == astm_pkg::LINK_RUN);

    generate
        for (genvar l = 0; l < NL; l++) begin : g_lane
            // Only the lowest L lanes run; the rest are held dark
            assign lane_active[l] =
                running && (4'(l) < params.lanes);
            assign lane_identifier[l] = astm_pkg::LANE_ID_W'(l);

            // A frame is built straight from one sample set, no buffer
            always_comb begin
                next_frame[l] = lane_frame[l];
                if (!lane_active[l])
                    next_frame[l] = '0;
                else if (sample_valid)
                    next_frame[l] = build(mode, l, sample_in);
            end
        end
    endgenerate

    // Frame strobe follows each accepted sample set by one cycle
    always_comb begin
        next_fvalid = running && sample_valid && (params.lanes != '0);
    end

    // Frame registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lane_frame  <= '0;
            frame_valid <= 1'b0;
        end else begin
            lane_frame  <= next_frame;
            frame_valid <= next_fvalid;
        end
    end

    // ==========================================================
    // Status outputs
    assign device_identifier = dev_id;
    assign link_params       = params;
    assign link_running      = running;
    assign config_error      = cfg_err;

endmodule : astm_mapper

// >>> bench/astm_checker.sv
// Port-level assertions for the transport mapper, bound to its top.
`timescale 1ns/100ps
module astm_checker #(
    parameter  int NUM_CH = 4,
    localparam int NL     = (NUM_CH > 1) ? 8 : 4
) (
    // Clock and reset
    input wire logic                                 clock,
    input wire logic                                 arst_n,
    // Sample strobe
    input wire logic                                 sample_valid,
    // Lane side
    input wire logic [NL-1:0][astm_pkg::FRAME_W-1:0] lane_frame,
    input wire logic [NL-1:0]                        lane_active,
    input wire logic                                 frame_valid,
    input wire logic [NL-1:0][2:0]                   lane_identifier,
    input wire logic [7:0]                           device_identifier,
    // Link status
    input wire astm_pkg::astm_link_params_t          link_params,
    input wire logic                                 link_running
);
    // ==========================================================
    // Pad and tail positions of the mode 0 and mode 3 padded layouts
    localparam logic [63:0] PAD0_MASK = 64'h007007007007007f;
    localparam logic [63:0] PAD3_MASK = 64'h0040100401ffffff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // Link-wide relations
    frame_cause_a: assert property (frame_valid |->
        $past(sample_valid) && $past(link_running))
        else $error("frame without samples");
    frame_resp_a: assert property (sample_valid && link_running
        && lane_active[0] |=> frame_valid) else $error("frame missing");
    low_lanes_a: assert property ((lane_active & (lane_active + 1'b1))
        == '0) else $error("active lanes not lowest");
    idle_dark_a: assert property (!link_running |-> lane_active == '0)
        else $error("lane active while idle");
    k_fixed_a: assert property (link_running && link_params.enc_64b
        |-> link_params.frames_k == 9'h080) else $error("bad derived K");
    hold_cfg_a: assert property (link_running && $past(link_running)
        |-> $stable(link_params) && $stable(device_identifier))
        else $error("config moved while running");
    mode3_par_a: assert property (link_running
        && link_params.octets_f == 4'h5 |-> !link_params.enc_64b
        && link_params.samples_s == 3'h4 && link_params.width_np == 4'ha)
        else $error("mode 3 parameters wrong");
    m_eq_l_a: assert property (link_running
        && link_params.octets_f == 4'h8 |->
        link_params.conv_m == link_params.lanes) else $error("M differs");

    // ==========================================================
    // Per-lane relations
    for (genvar i = 0; i < NL; i++) begin : g_lane
        lane_id_a: assert property (lane_identifier[i] == 3'(i))
            else $error("lane id wrong");
        lane_off_a: assert property (!lane_active[i]
            && $past(!lane_active[i]) |-> lane_frame[i] == '0)
            else $error("dark lane carries data");
        pad12_a: assert property (frame_valid && lane_active[i]
            && link_params.octets_f == 4'h8 |->
            (lane_frame[i] & PAD0_MASK) == '0) else $error("mode 0 pad");
        pad10_a: assert property (frame_valid && lane_active[i]
            && link_params.octets_f == 4'h5 |->
            (lane_frame[i] & PAD3_MASK) == '0) else $error("mode 3 pad");
    end
endmodule : astm_checker

bind astm_mapper astm_checker #(.NUM_CH(NUM_CH)) u_checker (.clock,
    .arst_n, .sample_valid, .lane_frame, .lane_active, .frame_valid,
    .lane_identifier, .device_identifier, .link_params, .link_running);

// >>> bench/astm_rx_model.sv
// Behavioural receiver rebuilding channel A from the two lowest lanes.
`timescale 1ns/100ps
module astm_rx_model (
    // Clock
    input wire logic             clock,
    // Lowest two lanes only; higher lanes are never wired here
    input wire logic [1:0][63:0] lane_frame_low,
    input wire logic             frame_valid,
    // Channel A stream, oldest sample first
    output logic [9:0][8:0]      chan_a
);
    // Even samples ride lane 0, odd ones lane 1: interleave them back
    always_ff @(posedge clock) begin
        if (frame_valid) begin
            for (int n = 0; n < 10; n++) begin
                chan_a[n] <= lane_frame_low[n % 2][63 - 12 * (n / 2) -: 9];
            end
        end
    end
endmodule : astm_rx_model

// >>> bench/astm_mapper_tb.sv
// Self-checking bench for the transport mapper.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module astm_mapper_tb;
    localparam int NL = 8;
    logic                       clock, arst_n, link_enable, sample_valid;
    logic [3:0]                 link_mode_select;
    logic [8:0]                 k_setting;
    logic [7:0]                 device_identifier_setting, device_identifier;
    astm_pkg::astm_frame_in_t   sample_in;
    logic [NL-1:0][63:0]        lane_frame;
    logic [NL-1:0]              lane_active;
    logic [NL-1:0][2:0]         lane_identifier;
    logic                       frame_valid, link_running, config_error;
    astm_pkg::astm_link_params_t link_params;
    logic [9:0][8:0]            rx_a;
    int                         num_errors = 0;
    int                         samples_checked = 0;

    astm_mapper #(.NUM_CH(4)) dut (.clock, .arst_n, .link_enable,
        .link_mode_select, .k_setting, .device_identifier_setting,
        .sample_in, .sample_valid, .lane_frame, .lane_active, .frame_valid,
        .lane_identifier, .device_identifier, .link_params, .link_running,
        .config_error);
    astm_rx_model u_rx (.clock, .lane_frame_low(lane_frame[1:0]),
        .frame_valid, .chan_a(rx_a));

    // ==========================================================
    // Helpers: bit 8 and bit 0 both set so a shifted or truncated sample shows up
    function automatic logic [8:0] sv(int ch, int n);
        return 9'h101 | 9'(ch << 5) | 9'(n << 1);
    endfunction : sv

    function automatic logic [63:0] exp_frame(logic [3:0] m, int l);
        logic [63:0] e;
        logic [8:0]  a0, a1, b0, b1;
        e = '0;
        a0 = sv(2 * (l / 3), 0);
        a1 = sv(2 * (l / 3), 1);
        b0 = sv(2 * (l / 3) + 1, 0);
        b1 = sv(2 * (l / 3) + 1, 1);
        case (m)
            4'h0: begin
                for (int i = 0; i < 5; i++)
                    e = (e << 12) | 64'({sv(l / 2, l % 2 + 2 * i), 3'h0});
                e = e << 4;
            end
            4'h1: e = (l % 3 == 0) ? {a0, 3'h0, a1[8:5], 48'h0}
                    : (l % 3 == 1) ? {a1[4:0], 3'h0, b0[8:1], 48'h0}
                    : {b0[0], 3'h0, b1, 3'h0, 48'h0};
            4'h2: begin
                a0 = sv(l, 0);
                e = {a0[8:1], 56'h0};
            end
            4'h3: begin
                for (int i = 0; i < 4; i++)
                    e = (e << 10) | 64'({sv(l, i), 1'b0});
                e = e << 24;
            end
            default: begin
                a0 = sv(2 * l, 0);
                b0 = sv(2 * l + 1, 0);
                e = {a0[8:1], b0[8:1], 48'h0};
            end
        endcase
        return e;
    endfunction : exp_frame

    task automatic tick(int n);
        repeat (n) @(negedge clock);
    endtask : tick

    task automatic finish_test();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // Idle one cycle, then present a new setting on the enable edge
    task automatic link_up(logic [3:0] m, logic [8:0] k, logic [7:0] id);
        link_enable = 1'b0;
        tick(1);
        link_mode_select = m;
        k_setting = k;
        device_identifier_setting = id;
        link_enable = 1'b1;
        tick(1);
    endtask : link_up

    task automatic link_down();
        link_enable = 1'b0;
        tick(2);
    endtask : link_down

    // ==========================================================
    // Scenario: one mode, its parameters and one full frame
    task automatic test_mode(logic [3:0] m, int nl, logic [3:0] f,
                             logic [8:0] k, logic [8:0] kx,
                             logic [3:0] mx);
        int t;
        link_up(m, k, 8'(m) + 8'h5a);
        `CHK(link_params.lanes, 4'(nl))
        `CHK(link_params.octets_f, f)
        `CHK(link_params.conv_m, mx)
        `CHK(link_params.enc_64b, m == 4'h5)
        `CHK(link_params.frames_k, kx)
        `CHK(lane_active, NL'((1 << nl) - 1))
        `CHK(device_identifier, 8'(m) + 8'h5a)
        `CHK(config_error, 1'b0)
        sample_valid = 1'b1;
        tick(1);
        sample_valid = 1'b0;
        for (t = 0; t < 4 && frame_valid !== 1'b1; t++) tick(1);
        if (t == 4) begin
            num_errors++;
            finish_test();
        end
        for (int l = 0; l < NL; l++)
            `CHK(lane_frame[l], l < nl ? exp_frame(m, l) : 64'h0)
        tick(1);
        `CHK(frame_valid, 1'b0)
        link_down();
    endtask : test_mode

    // Scenario: unmapped mode, off-step K, changes while running
    task automatic scen_refuse();
        link_up(4'h4, 9'h080, 8'h11);
        `CHK(config_error, 1'b1)
        `CHK(lane_active, 8'h00)
        sample_valid = 1'b1;
        tick(1);
        sample_valid = 1'b0;
        tick(1);
        `CHK(frame_valid, 1'b0)
        link_up(4'h3, 9'h030, 8'h22);
        `CHK(config_error, 1'b1)
        link_mode_select = 4'h0;
        k_setting = 9'h004;
        tick(2);
        `CHK(link_params.lanes, 4'h4)
        `CHK(link_params.frames_k, 9'h020)
        link_down();
        `CHK(lane_active, 8'h00)
    endtask : scen_refuse

    // ==========================================================
    // Clock, reset and main sequence
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        {arst_n, link_enable, sample_valid} = '0;
        link_mode_select = 4'h0;
        k_setting = 9'h020;
        device_identifier_setting = 8'h00;
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < 10; n++)
                sample_in.smp[c][n] = sv(c, n);
        tick(20);
        arst_n = 1'b1;
        tick(1);
        `CHK(link_running, 1'b0)
        for (int l = 0; l < NL; l++)
            `CHK(lane_identifier[l], 3'(l))
        test_mode(4'h0, 8, 4'h8, 9'h004, 9'h004, 4'h8);
        for (int n = 0; n < 10; n++)
            `CHK(rx_a[n], sv(0, n))
        test_mode(4'h1, 6, 4'h2, 9'h100, 9'h100, 4'h4);
        test_mode(4'h2, 4, 4'h1, 9'h020, 9'h020, 4'h4);
        test_mode(4'h3, 4, 4'h5, 9'h100, 9'h100, 4'h4);
        test_mode(4'h5, 2, 4'h2, 9'h004, 9'h080, 4'h4);
        scen_refuse();
        finish_test();
    end
endmodule : astm_mapper_tb
